// ==== design/windowed_watchdog_timer.v ====
`timescale 1ns/1ps
`include "wdog_defines.vh"

// ==========================================================
// windowed watchdog
module windowed_watchdog_timer
(
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire tick_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output wire ack_o,
    output reg wdt_reset_o
);

// ==========================================================
// bus slave
reg ack_q;
wire req = cyc_i & stb_i & ~ack_q;
wire wr = req & we_i;
// control write needs all three low byte lanes
wire ctrl_wr = wr & (adr_i == `WDOG_CTRL_ADDR) & sel_i[0] & sel_i[1] & sel_i[2];
// clear needs only the low byte lane
wire clr_wr = wr & (adr_i == `WDOG_CLR_ADDR) & sel_i[0];
// ack follows a taken request by one cycle; ce_i low holds it
assign ack_o = ack_q;

// ==========================================================
// register state
// software-side shadow of the control fields
reg en_sw_q;
reg mode_sw_q;
reg [4:0] psel_sw_q;
reg [4:0] ban_sw_q;
// watchdog-side live copy
// enable reads back only once it lands here
reg en_q;
reg mode_q;
reg [4:0] psel_q;
reg [4:0] ban_q;
reg [1:0] sync_cnt_q;
reg busy_q;
reg clr_pend_q;
reg [31:0] cnt_q;

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_q <= 1'b0;
        en_sw_q <= 1'b0;
        mode_sw_q <= 1'b0;
        psel_sw_q <= `WDOG_PSEL_RST;
        ban_sw_q <= `WDOG_BAN_RST;
    end
    else if (ce_i)
    begin
        ack_q <= req;
        if (ctrl_wr)
        begin
            // launch sync of all fields
            en_sw_q <= dat_i[`WDOG_EN_BIT];
            mode_sw_q <= dat_i[`WDOG_MODE_BIT];
            psel_sw_q <= dat_i[`WDOG_PSEL_MSB:`WDOG_PSEL_LSB];
            ban_sw_q <= dat_i[`WDOG_BAN_MSB:`WDOG_BAN_LSB];
        end
    end
end

// ==========================================================
// synchronizer into the watchdog tick domain
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        en_q <= 1'b0;
        mode_q <= 1'b0;
        psel_q <= `WDOG_PSEL_RST;
        ban_q <= `WDOG_BAN_RST;
        sync_cnt_q <= 2'h0;
        busy_q <= 1'b0;
    end
    else if (ce_i)
    begin
        if (ctrl_wr)
        begin
            // restart sync; overlapping writes are software's fault
            busy_q <= 1'b1;
            sync_cnt_q <= 2'h0;
        end
        else if (busy_q && tick_i)
        begin
            if (sync_cnt_q == `WDOG_SYNC_TICKS - 2'h1)
            begin
                // all fields land together when the count expires
                busy_q <= 1'b0;
                en_q <= en_sw_q;
                mode_q <= mode_sw_q;
                psel_q <= psel_sw_q;
                ban_q <= ban_sw_q;
            end
            else
            begin
                sync_cnt_q <= sync_cnt_q + 2'h1;
            end
        end
    end
end

// ==========================================================
// counter and window check
// timeout is 2^psel ticks; a clear at or past half of it asserts reset
// psel of zero wraps the half shift, so software avoids it
wire [31:0] timeout = 32'h1 << psel_q;
wire [31:0] half = 32'h1 << (psel_q - 5'h1);
wire in_second_half = (cnt_q >= half);

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        cnt_q <= 32'h0;
        clr_pend_q <= 1'b0;
        wdt_reset_o <= 1'b0;
    end
    else if (ce_i)
    begin
        if (clr_wr)
        begin
            clr_pend_q <= 1'b1;
        end
        if (!en_q)
        begin
            cnt_q <= 32'h0;
            clr_pend_q <= 1'b0;
        end
        // a clear acts one cycle after its write and wins over a tick
        // landing in that same cycle
        else if (clr_pend_q && !clr_wr)
        begin
            clr_pend_q <= 1'b0;
            if (in_second_half)
            begin
                wdt_reset_o <= 1'b1;
            end
            else
            begin
                cnt_q <= 32'h0;
            end
        end
        else if (tick_i)
        begin
            // count stops at the last step; reset stays until rst_i
            if (cnt_q >= timeout - 32'h1)
            begin
                wdt_reset_o <= 1'b1;
            end
            else
            begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
end

// ==========================================================
// read data
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        dat_o <= 32'h0;
    end
    else if (ce_i && req)
    begin
        dat_o <= 32'h0;
        case (adr_i)
            `WDOG_CTRL_ADDR:
            begin
                // only enable shows the synced copy; others echo the shadow
                // mode and ban select are stored only
                dat_o[`WDOG_EN_BIT] <= en_q;
                dat_o[`WDOG_MODE_BIT] <= mode_sw_q;
                dat_o[`WDOG_PSEL_MSB:`WDOG_PSEL_LSB] <= psel_sw_q;
                dat_o[`WDOG_BAN_MSB:`WDOG_BAN_LSB] <= ban_sw_q;
            end
            `WDOG_STAT_ADDR:
            begin
                // busy covers the enable bit alone
                dat_o[`WDOG_ST_EN_BIT] <= en_q;
                dat_o[`WDOG_ST_BUSY_BIT] <= busy_q & (en_q ^ en_sw_q);
                dat_o[`WDOG_ST_RST_BIT] <= wdt_reset_o;
            end
            `WDOG_CNT_ADDR:
            begin
                dat_o <= cnt_q;
            end
            default:
            begin
                dat_o <= 32'h0;
            end
        endcase
    end
end

endmodule // windowed_watchdog_timer

// ==== pkg/wdog_defines.vh ====
`ifndef WDOG_DEFINES_VH
`define WDOG_DEFINES_VH

// register byte offsets
`define WDOG_CTRL_ADDR 4'h0
`define WDOG_CLR_ADDR 4'h4
`define WDOG_STAT_ADDR 4'h8
`define WDOG_CNT_ADDR 4'hC

// control field positions
`define WDOG_EN_BIT 0
`define WDOG_MODE_BIT 1
`define WDOG_PSEL_LSB 8
`define WDOG_PSEL_MSB 12
`define WDOG_BAN_LSB 16
`define WDOG_BAN_MSB 20

// status field positions
`define WDOG_ST_EN_BIT 0
`define WDOG_ST_BUSY_BIT 1
`define WDOG_ST_RST_BIT 2

// reset values
`define WDOG_PSEL_RST 5'h0A
`define WDOG_BAN_RST 5'h00

// synchronizer length in watchdog ticks
`define WDOG_SYNC_TICKS 2'h2

`endif

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "wdog_defines.vh"
// ======
// bench
module testbench;
reg clk_i = 1'b0;
reg rst_i = 1'b1;
reg ce_i = 1'b1;
reg tick_i = 1'b0;
reg cyc_i = 1'b0;
reg stb_i = 1'b0;
reg we_i = 1'b0;
reg [3:0] adr_i = 4'h0;
reg [31:0] dat_i = 32'h0;
wire [31:0] dat_o;
wire ack_o;
wire wdt_reset_o;
reg [31:0] rd;
integer n_errors = 0;
integer check_count = 0;
integer cyc_n = 0;
windowed_watchdog_timer uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(tick_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .wdt_reset_o(wdt_reset_o));
initial forever #2 clk_i = ~clk_i;
task final_report;
    begin
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
endtask
always @(posedge clk_i)
begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 3000)
    begin
        n_errors = n_errors + 1;
        final_report;
    end
end
task chk(input [31:0] g, input [31:0] e);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    end
endtask
task bus(input w, input [3:0] a, input [31:0] d);
    begin
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    end
endtask
task tk(input integer n);
    begin
        repeat (n)
        begin
            tick_i <= 1'b1;
            @(posedge clk_i);
            tick_i <= 1'b0;
            @(posedge clk_i);
        end
    end
endtask
task rs;
    begin
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    end
endtask
task rdc(input [3:0] a, input [31:0] e);
    begin
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    end
endtask
task t_sync;
    begin
        rdc(4'h2, 32'h0);
        bus(1'b1, `WDOG_CTRL_ADDR, 32'h301);
        rdc(`WDOG_CTRL_ADDR, 32'h300);
        rdc(`WDOG_STAT_ADDR, 32'h2);
        tk(2);
        rdc(`WDOG_CTRL_ADDR, 32'h301);
    end
endtask
task t_ce;
    begin
        tk(2);
        ce_i <= 1'b0;
        tk(3);
        ce_i <= 1'b1;
        rdc(`WDOG_CNT_ADDR, 32'h2);
    end
endtask
task t_win;
    begin
        bus(1'b1, `WDOG_CLR_ADDR, 32'h1);
        tk(3);
        rdc(`WDOG_CNT_ADDR, 32'h3);
        bus(1'b1, `WDOG_CLR_ADDR, 32'h1);
        rdc(`WDOG_CNT_ADDR, 32'h0);
        tk(4);
        bus(1'b1, `WDOG_CLR_ADDR, 32'h1);
        rdc(`WDOG_STAT_ADDR, 32'h5);
    end
endtask
task t_none;
    begin
        rs;
        bus(1'b1, `WDOG_CTRL_ADDR, 32'h301);
        tk(2);
        bus(1'b1, `WDOG_CLR_ADDR, 32'h1);
        tk(7);
        rdc(`WDOG_STAT_ADDR, 32'h1);
        tk(1);
        rdc(`WDOG_STAT_ADDR, 32'h5);
    end
endtask
initial
begin
    rs;
    rdc(`WDOG_CTRL_ADDR, 32'h00000A00);
    t_sync;
    t_ce;
    t_win;
    t_none;
    final_report;
end
endmodule // testbench

// ==== sim/wdog_asserts.sv ====
`timescale 1ns/1ps
`include "wdog_defines.vh"
// ======
// checker
module wdog_asserts
(
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire tick_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire ack_o,
    input wire wdt_reset_o
);
wire clr = cyc_i & stb_i & we_i & (adr_i == `WDOG_CLR_ADDR);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
a_ack_next: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o) else $error("no ack");
a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o) else $error("ack long");
a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
a_rst_sticky: assert property (wdt_reset_o |=> wdt_reset_o) else $error("rst drop");
a_rst_cause: assert property ($rose(wdt_reset_o) |-> $past(tick_i) || $past(clr)
    || $past(clr, 2)) else $error("rst cause");
endmodule // wdog_asserts
bind windowed_watchdog_timer wdog_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .tick_i(tick_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .ack_o(ack_o), .wdt_reset_o(wdt_reset_o));
